// ===== logic/jtag_flash_program_access.sv
// Flash programming access through indirect test-port data registers.
// Assumes the TAP controller drives the capture/shift/update strobes on i_tck,
// and a flash macro on i_clk_sys that answers each request with one done pulse.
// What this block does
// - Scratchpad bit steers accesses to scratchpad
// - Write mode 000 only stores data
// - Write mode 001 programs byte, then increments
// - Mode 010 with 0xA5 erases page
// - Lock byte erase wipes whole user space
// - Read mode 0000 returns contents only
// - Read mode 0001 starts read when idle
// - Read mode 0010 needs idle and consumed
// - Data register ten bits, byte in 9:2
// - Bit 1 reports previous operation failure
// - Bit 0 busy blocks new operations
// - Address feeds all ops, increments after flash read/program
// - Opcode in 19:18, write data left-justified
// - Busy at bit 0, commands ignored while busy
module jtag_flash_program_access #(
  parameter logic [15:0] LOCK_RD_ADDR = 16'hFFFE,
  parameter logic [15:0] LOCK_WE_ADDR = 16'hFFFF
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_resetn,
  input  wire logic                       i_tck,
  input  wire logic                       i_tdi,
  input  wire logic                       i_capture_dr,
  input  wire logic                       i_shift_dr,
  input  wire logic                       i_update_dr,
  input  wire logic [1:0]                 i_dr_sel,
  output logic                            o_tdo,
  output logic                            o_flash_req,
  output flash_prog_pkg::flash_op_type    o_flash_op,
  output logic [15:0]                     o_flash_addr,
  output logic                            o_flash_scratch,
  output logic [7:0]                      o_flash_wdata,
  input  wire logic                       i_flash_done,
  input  wire logic                       i_flash_fail,
  input  wire logic [7:0]                 i_flash_rdata
);
  // ---------------- Test-clock side ----------------
  logic [flash_prog_pkg::CMD_W-1:0]  shift_r, shift_nxt;
  logic                              req_tgl_r, req_tgl_nxt;
  logic [1:0]                        cmd_op_r, cmd_op_nxt;
  logic [flash_prog_pkg::SEL_W-1:0]  cmd_sel_r, cmd_sel_nxt;
  logic [flash_prog_pkg::WORD_W-1:0] cmd_word_r, cmd_word_nxt;
  logic                              ack_tck;
  logic                              link_busy;
  logic [flash_prog_pkg::WORD_W-1:0] rsp_r, rsp_nxt;
  logic                              ack_tgl_r, ack_tgl_nxt;

  sync2 #(.W(1)) u_ack_sync (
    .i_clk    (i_tck),
    .i_resetn (i_resetn),
    .i_d      (ack_tgl_r),
    .o_q      (ack_tck)
  );

  assign link_busy = req_tgl_r ^ ack_tck;

  always_comb begin
    shift_nxt    = shift_r;
    req_tgl_nxt  = req_tgl_r;
    cmd_op_nxt   = cmd_op_r;
    cmd_sel_nxt  = cmd_sel_r;
    cmd_word_nxt = cmd_word_r;
    if (i_capture_dr) begin
      shift_nxt = {1'b0, (link_busy ? {flash_prog_pkg::WORD_W{1'b0}} : rsp_r), link_busy};
    end else if (i_shift_dr) begin
      shift_nxt = {i_tdi, shift_r[flash_prog_pkg::CMD_W-1:1]};
    end else if (i_update_dr) begin
      if (shift_r[flash_prog_pkg::OP_HI] && !link_busy) begin
        req_tgl_nxt  = ~req_tgl_r;
        cmd_op_nxt   = shift_r[flash_prog_pkg::OP_HI:flash_prog_pkg::OP_LO];
        cmd_sel_nxt  = i_dr_sel;
        cmd_word_nxt = shift_r[flash_prog_pkg::WORD_W-1:0];
      end
    end
  end

  always_ff @(posedge i_tck or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_r    <= '0;
      req_tgl_r  <= 1'b0;
      cmd_op_r   <= '0;
      cmd_sel_r  <= '0;
      cmd_word_r <= '0;
      o_tdo      <= 1'b0;
    end else begin
      shift_r    <= shift_nxt;
      req_tgl_r  <= req_tgl_nxt;
      cmd_op_r   <= cmd_op_nxt;
      cmd_sel_r  <= cmd_sel_nxt;
      cmd_word_r <= cmd_word_nxt;
      o_tdo      <= shift_nxt[0];
    end
  end

  property p_ignore_busy;
    @(posedge i_tck) disable iff (!i_resetn)
      (i_update_dr && !i_capture_dr && !i_shift_dr && link_busy) |=> $stable(req_tgl_r);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("command taken while busy");

  // ---------------- System-clock side ----------------
  logic                                req_sys;
  logic                                req_prev_r;
  logic                                req_evt;
  logic [flash_prog_pkg::CTRL_W-1:0]   ctrl_r, ctrl_nxt;
  logic [flash_prog_pkg::BYTE_W-1:0]   byte_r, byte_nxt;
  logic                                fail_r, fail_nxt;
  logic [flash_prog_pkg::ADDR_W-1:0]   addr_r, addr_nxt;
  logic                                unread_r, unread_nxt;
  flash_prog_pkg::seq_state_type       state_r, state_nxt;
  flash_prog_pkg::flash_op_type        op_nxt;
  logic                                flash_req_nxt;
  logic [15:0]                         flash_addr_nxt;
  logic                                scratch_nxt;
  logic [7:0]                          wdata_nxt;
  logic                                is_wr, is_rd, sel_data;
  logic [2:0]                          wmode;
  logic [3:0]                          rmode;
  logic [7:0]                          wbyte;
  logic                                idle;

  sync2 #(.W(1)) u_req_sync (
    .i_clk    (i_clk_sys),
    .i_resetn (i_resetn),
    .i_d      (req_tgl_r),
    .o_q      (req_sys)
  );

  assign req_evt  = req_sys ^ req_prev_r;
  assign is_wr    = (cmd_op_r == flash_prog_pkg::OP_WRITE);
  assign is_rd    = (cmd_op_r == flash_prog_pkg::OP_READ);
  assign sel_data = (cmd_sel_r == flash_prog_pkg::SEL_DATA);
  assign wmode    = ctrl_r[flash_prog_pkg::WMODE_HI:flash_prog_pkg::WMODE_LO];
  assign rmode    = ctrl_r[flash_prog_pkg::RMODE_HI:flash_prog_pkg::RMODE_LO];
  assign wbyte    = cmd_word_r[flash_prog_pkg::WORD_W-1:flash_prog_pkg::WBYTE_LO];
  assign idle     = (state_r == flash_prog_pkg::ST_IDLE);

  always_comb begin
    ctrl_nxt       = ctrl_r;
    byte_nxt       = byte_r;
    fail_nxt       = fail_r;
    addr_nxt       = addr_r;
    unread_nxt     = unread_r;
    state_nxt      = state_r;
    rsp_nxt        = rsp_r;
    ack_tgl_nxt    = ack_tgl_r;
    flash_req_nxt  = 1'b0;
    op_nxt         = o_flash_op;
    flash_addr_nxt = o_flash_addr;
    scratch_nxt    = o_flash_scratch;
    wdata_nxt      = o_flash_wdata;
    if (req_evt) begin
      ack_tgl_nxt = req_sys;
      if (is_wr) begin
        case (cmd_sel_r)
          flash_prog_pkg::SEL_CONTROL: ctrl_nxt = cmd_word_r[flash_prog_pkg::WORD_W-1:flash_prog_pkg::WCTRL_LO];
          flash_prog_pkg::SEL_ADDR:    addr_nxt = cmd_word_r[flash_prog_pkg::WORD_W-1:flash_prog_pkg::WADDR_LO];
          flash_prog_pkg::SEL_DATA: begin
            byte_nxt = wbyte;
            if (idle) begin
              if (wmode == flash_prog_pkg::WMODE_PROG) begin
                flash_req_nxt = 1'b1;
                op_nxt        = flash_prog_pkg::FOP_PROG;
              end else if (wmode == flash_prog_pkg::WMODE_ERASE && wbyte == flash_prog_pkg::ERASE_KEY) begin
                flash_req_nxt = 1'b1;
                op_nxt = (addr_r == LOCK_RD_ADDR || addr_r == LOCK_WE_ADDR) ?
                         flash_prog_pkg::FOP_ERASE_ALL : flash_prog_pkg::FOP_ERASE_PAGE;
              end
            end
          end
          default: ;
        endcase
      end else if (is_rd) begin
        case (cmd_sel_r)
          flash_prog_pkg::SEL_CONTROL: rsp_nxt = {10'h000, ctrl_r};
          flash_prog_pkg::SEL_ADDR:    rsp_nxt = {2'h0, addr_r};
          flash_prog_pkg::SEL_DATA: begin
            rsp_nxt    = {8'h00, byte_r, fail_r, !idle};
            unread_nxt = 1'b0;
            if (idle && (rmode == flash_prog_pkg::RMODE_BLOCK ||
                         (rmode == flash_prog_pkg::RMODE_SINGLE && !unread_r))) begin
              flash_req_nxt = 1'b1;
              op_nxt        = flash_prog_pkg::FOP_READ;
            end
          end
          default: rsp_nxt = '0;
        endcase
      end
    end
    if (flash_req_nxt) begin
      state_nxt      = flash_prog_pkg::ST_WAIT;
      flash_addr_nxt = addr_r;
      scratch_nxt    = ctrl_r[flash_prog_pkg::SCRATCH_BIT];
      wdata_nxt      = wbyte;
    end
    if (state_r == flash_prog_pkg::ST_WAIT && i_flash_done) begin
      state_nxt = flash_prog_pkg::ST_IDLE;
      fail_nxt  = i_flash_fail;
      if (o_flash_op == flash_prog_pkg::FOP_READ) begin
        byte_nxt   = i_flash_rdata;
        unread_nxt = 1'b1;
      end
      if (o_flash_op == flash_prog_pkg::FOP_READ || o_flash_op == flash_prog_pkg::FOP_PROG) begin
        addr_nxt = addr_r + flash_prog_pkg::ADDR_ONE;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      req_prev_r      <= 1'b0;
      ctrl_r          <= flash_prog_pkg::CTRL_RESET;
      byte_r          <= flash_prog_pkg::BYTE_RESET;
      fail_r          <= 1'b0;
      addr_r          <= flash_prog_pkg::ADDR_RESET;
      unread_r        <= 1'b0;
      state_r         <= flash_prog_pkg::ST_IDLE;
      rsp_r           <= '0;
      ack_tgl_r       <= 1'b0;
      o_flash_req     <= 1'b0;
      o_flash_op      <= flash_prog_pkg::FOP_READ;
      o_flash_addr    <= flash_prog_pkg::ADDR_RESET;
      o_flash_scratch <= 1'b0;
      o_flash_wdata   <= flash_prog_pkg::BYTE_RESET;
    end else begin
      req_prev_r      <= req_sys;
      ctrl_r          <= ctrl_nxt;
      byte_r          <= byte_nxt;
      fail_r          <= fail_nxt;
      addr_r          <= addr_nxt;
      unread_r        <= unread_nxt;
      state_r         <= state_nxt;
      rsp_r           <= rsp_nxt;
      ack_tgl_r       <= ack_tgl_nxt;
      o_flash_req     <= flash_req_nxt;
      o_flash_op      <= op_nxt;
      o_flash_addr    <= flash_addr_nxt;
      o_flash_scratch <= scratch_nxt;
      o_flash_wdata   <= wdata_nxt;
    end
  end

  logic wr_data_evt, rd_data_evt;
  assign wr_data_evt = req_evt && is_wr && sel_data;
  assign rd_data_evt = req_evt && is_rd && sel_data;

  property p_store_only;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (wr_data_evt && wmode == flash_prog_pkg::WMODE_STORE) |=> !o_flash_req ##0 byte_r == $past(wbyte);
  endproperty
  a_store_only: assert property (p_store_only) else $error("store-only write started flash");

  property p_prog_start;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (wr_data_evt && idle && wmode == flash_prog_pkg::WMODE_PROG) |=>
        o_flash_req && o_flash_op == flash_prog_pkg::FOP_PROG && o_flash_addr == $past(addr_r);
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("program not started");

  property p_erase_key;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (wr_data_evt && wmode == flash_prog_pkg::WMODE_ERASE && wbyte != flash_prog_pkg::ERASE_KEY) |=> !o_flash_req;
  endproperty
  a_erase_key: assert property (p_erase_key) else $error("erase without key");

  property p_erase_keep;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (state_r == flash_prog_pkg::ST_WAIT && i_flash_done && !req_evt &&
       (o_flash_op == flash_prog_pkg::FOP_ERASE_PAGE || o_flash_op == flash_prog_pkg::FOP_ERASE_ALL))
        |=> $stable(addr_r);
  endproperty
  a_erase_keep: assert property (p_erase_keep) else $error("erase moved address");

  property p_incr;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (state_r == flash_prog_pkg::ST_WAIT && i_flash_done && !req_evt &&
       (o_flash_op == flash_prog_pkg::FOP_READ || o_flash_op == flash_prog_pkg::FOP_PROG))
        |=> addr_r == $past(addr_r) + flash_prog_pkg::ADDR_ONE;
  endproperty
  a_incr: assert property (p_incr) else $error("address not incremented");

  property p_no_req_busy;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (state_r == flash_prog_pkg::ST_WAIT && !i_flash_done) |=> !o_flash_req;
  endproperty
  a_no_req_busy: assert property (p_no_req_busy) else $error("request while busy");

  property p_single;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (rd_data_evt && rmode == flash_prog_pkg::RMODE_SINGLE && unread_r) |=> !o_flash_req ##1 !unread_r;
  endproperty
  a_single: assert property (p_single) else $error("single read restarted early");

  property p_block;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (rd_data_evt && idle && rmode == flash_prog_pkg::RMODE_BLOCK) |=>
        o_flash_req && o_flash_op == flash_prog_pkg::FOP_READ;
  endproperty
  a_block: assert property (p_block) else $error("block read not started");

  property p_fail_bit;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (state_r == flash_prog_pkg::ST_WAIT && i_flash_done) |=> fail_r == $past(i_flash_fail) ##0 idle;
  endproperty
  a_fail_bit: assert property (p_fail_bit) else $error("fail bit wrong");

  property p_scratch;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      o_flash_req |-> o_flash_scratch == ctrl_r[flash_prog_pkg::SCRATCH_BIT];
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratchpad select lost");
endmodule : jtag_flash_program_access

// ===== logic/flash_prog_pkg.sv
// Constants and types shared by the flash programming access block.
// Assumes one system clock domain and one test-clock domain.
package flash_prog_pkg;
  // Indirect command word
  localparam int          CMD_W        = 20;
  localparam int          OP_HI        = 19;
  localparam int          OP_LO        = 18;
  localparam int          WORD_W       = 18;
  localparam logic [1:0]  OP_READ      = 2'h2;
  localparam logic [1:0]  OP_WRITE     = 2'h3;
  // Indirect register selects
  localparam int          SEL_W        = 2;
  localparam logic [1:0]  SEL_CONTROL  = 2'h0;
  localparam logic [1:0]  SEL_DATA     = 2'h1;
  localparam logic [1:0]  SEL_ADDR     = 2'h2;
  // Register widths and reset values
  localparam int          CTRL_W       = 8;
  localparam int          DATA_W       = 10;
  localparam int          ADDR_W       = 16;
  localparam int          BYTE_W       = 8;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [15:0] ADDR_RESET   = 16'h0000;
  localparam logic [15:0] ADDR_ONE     = 16'h0001;
  // Control register fields
  localparam int          SCRATCH_BIT  = 7;
  localparam int          WMODE_HI     = 6;
  localparam int          WMODE_LO     = 4;
  localparam int          RMODE_HI     = 3;
  localparam int          RMODE_LO     = 0;
  localparam logic [2:0]  WMODE_STORE  = 3'h0;
  localparam logic [2:0]  WMODE_PROG   = 3'h1;
  localparam logic [2:0]  WMODE_ERASE  = 3'h2;
  localparam logic [3:0]  RMODE_PLAIN  = 4'h0;
  localparam logic [3:0]  RMODE_BLOCK  = 4'h1;
  localparam logic [3:0]  RMODE_SINGLE = 4'h2;
  // Left-justified write positions inside the 18-bit word
  localparam int          WCTRL_LO     = 10;
  localparam int          WBYTE_LO     = 10;
  localparam int          WADDR_LO     = 2;
  localparam logic [7:0]  ERASE_KEY    = 8'hA5;

  typedef enum logic [3:0] {
    FOP_READ       = 4'h1,
    FOP_PROG       = 4'h2,
    FOP_ERASE_PAGE = 4'h4,
    FOP_ERASE_ALL  = 4'h8
  } flash_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_WAIT = 2'h2
  } seq_state_type;
endpackage : flash_prog_pkg

// ===== logic/sync2.sv
// Two-flop level synchroniser.
// Assumes i_d is a level that stays stable long enough to be caught.
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= '0;
      o_q    <= '0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule : sync2

// ===== dv/flash_macro_model.sv
// Behavioural flash macro that answers the access block's requests.
// Assumes one request at a time; the bench sets the answer latency.
module flash_macro_model #(
  parameter logic [15:0] PAGE_MASK = 16'hFE00
) (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic [3:0]  i_op,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_scratch,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_fail_next,
  input  wire logic [9:0]  i_latency,
  output logic             o_done,
  output logic             o_fail,
  output logic [7:0]       o_rdata,
  output int               o_req_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [logic [16:0]];
  logic [16:0] key;
  logic [16:0] kill [$];

  initial begin
    o_done = 1'b0;
    o_fail = 1'b0;
    o_rdata = 8'h00;
    o_req_cnt = 0;
    forever begin
      @(posedge i_clk);
      if (i_req === 1'b1) begin
        key = {i_scratch, i_addr};
        o_req_cnt++;
        repeat (i_latency) @(posedge i_clk);
        #1;
        o_done = 1'b1;
        o_fail = i_fail_next;
        case (i_op)
          4'h1: o_rdata = mem.exists(key) ? mem[key] : 8'hFF;
          4'h2: if (!i_fail_next) mem[key] = i_wdata;
          4'h4: begin
            kill.delete();
            foreach (mem[j]) begin
              if (j[16] == key[16] && (j[15:0] & PAGE_MASK) == (key[15:0] & PAGE_MASK)) kill.push_back(j);
            end
            foreach (kill[n]) mem.delete(kill[n]);
          end
          default: mem.delete();
        endcase
        // Answer lines stop holding once done drops
        @(posedge i_clk);
        #1;
        o_done = 1'b0;
        o_fail = ~o_fail;
        o_rdata = ~o_rdata;
      end
    end
  end
endmodule : flash_macro_model

// ===== dv/jtag_flash_program_access_tb.sv
// Self-checking bench for the flash programming access block.
// Assumes the flash macro model and a free-running test clock.
module jtag_flash_program_access_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] LK [2] = '{16'hFFFE, 16'hFFFF};
  logic                         clk, tck, rstn, tdi, cap, shf, upd, tdo;
  logic [1:0]                   sel;
  logic                         freq, fscr, fdone, ffail, fail_next, last_scr;
  flash_prog_pkg::flash_op_type fop, last_op;
  logic [15:0]                  faddr, last_addr;
  logic [7:0]                   fwd, frd;
  logic [9:0]                   lat;
  logic [17:0]                  d;
  logic [19:0]                  sq;
  int                           req_cnt, c0, error_cnt, comparisons;

  jtag_flash_program_access #(
    .LOCK_RD_ADDR (LK[0]),
    .LOCK_WE_ADDR (LK[1])
  ) DUT (
    .i_clk_sys       (clk),
    .i_resetn        (rstn),
    .i_tck           (tck),
    .i_tdi           (tdi),
    .i_capture_dr    (cap),
    .i_shift_dr      (shf),
    .i_update_dr     (upd),
    .i_dr_sel        (sel),
    .o_tdo           (tdo),
    .o_flash_req     (freq),
    .o_flash_op      (fop),
    .o_flash_addr    (faddr),
    .o_flash_scratch (fscr),
    .o_flash_wdata   (fwd),
    .i_flash_done    (fdone),
    .i_flash_fail    (ffail),
    .i_flash_rdata   (frd)
  );

  flash_macro_model flash (
    .i_clk       (clk),
    .i_req       (freq),
    .i_op        (fop),
    .i_addr      (faddr),
    .i_scratch   (fscr),
    .i_wdata     (fwd),
    .i_fail_next (fail_next),
    .i_latency   (lat),
    .o_done      (fdone),
    .o_fail      (ffail),
    .o_rdata     (frd),
    .o_req_cnt   (req_cnt)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    tck = 1'b0;
    #3;
    forever #32 tck = ~tck;
  end
  always @(posedge clk) begin
    if (freq === 1'b1) begin
      last_op <= fop;
      last_addr <= faddr;
      last_scr <= fscr;
    end
  end

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic scan(input logic [1:0] s, input logic [19:0] w, output logic [19:0] q);
    @(posedge tck) #2;
    sel = s;
    cap = 1'b1;
    @(posedge tck) #2;
    cap = 1'b0;
    shf = 1'b1;
    for (int k = 0; k < 20; k++) begin
      q[k] = tdo;
      tdi = w[k];
      @(posedge tck) #2;
    end
    shf = 1'b0;
    upd = 1'b1;
    @(posedge tck) #2;
    upd = 1'b0;
  endtask : scan

  // Repeats the last update while the link is still busy
  task automatic dup();
    @(posedge tck) #2;
    upd = 1'b1;
    @(posedge tck) #2;
    upd = 1'b0;
  endtask : dup

  task automatic cmd(input logic [1:0] s, input logic [1:0] op, input logic [17:0] v);
    logic [19:0] q;
    int          n;
    scan(s, {op, v}, q);
    n = 0;
    do begin
      scan(s, 20'h00000, q);
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    check(18'(q[0]), 18'h00000);
    d = q[18:1];
  endtask : cmd

  task automatic wctl(input logic [7:0] c);
    cmd(flash_prog_pkg::SEL_CONTROL, flash_prog_pkg::OP_WRITE, {c, 10'h000});
  endtask : wctl
  task automatic wadr(input logic [15:0] a);
    cmd(flash_prog_pkg::SEL_ADDR, flash_prog_pkg::OP_WRITE, {a, 2'h0});
  endtask : wadr
  task automatic wdat(input logic [7:0] b);
    cmd(flash_prog_pkg::SEL_DATA, flash_prog_pkg::OP_WRITE, {b, 10'h000});
  endtask : wdat
  task automatic rdat();
    cmd(flash_prog_pkg::SEL_DATA, flash_prog_pkg::OP_READ, 18'h00000);
  endtask : rdat
  task automatic radr();
    cmd(flash_prog_pkg::SEL_ADDR, flash_prog_pkg::OP_READ, 18'h00000);
  endtask : radr
  task automatic reqs(input int n);
    check(18'(req_cnt - c0), 18'(n));
    c0 = req_cnt;
  endtask : reqs

  initial begin
    {tdi, cap, shf, upd} = 4'h0;
    sel = 2'h0;
    rstn = 1'b0;
    fail_next = 1'b0;
    lat = 10'h002;
    error_cnt = 0;
    comparisons = 0;
    c0 = 0;
    repeat (5) @(posedge clk);
    repeat (2) @(posedge tck);
    #2;
    rstn = 1'b1;
    cmd(flash_prog_pkg::SEL_CONTROL, flash_prog_pkg::OP_READ, 18'h00000);
    check(d, 18'h00000);
    rdat();
    check(d, 18'h00000);
    radr();
    check(d, 18'h00000);
    $display("test reset values done");
    wctl(8'h00);
    wdat(8'h3C);
    rdat();
    check(d, 18'h000F0);
    reqs(0);
    $display("test store mode done");
    wctl(8'h10);
    wadr(16'h0100);
    wdat(8'h5A);
    wdat(8'h6B);
    reqs(2);
    check(18'(last_op), 18'(flash_prog_pkg::FOP_PROG));
    check({last_scr, 1'b0, last_addr}, 18'h00101);
    radr();
    check(d, 18'h00102);
    fail_next = 1'b1;
    wdat(8'h11);
    fail_next = 1'b0;
    rdat();
    check(d, 18'h00046);
    radr();
    check(d, 18'h00103);
    wdat(8'h22);
    rdat();
    check(d, 18'h00088);
    reqs(2);
    $display("test program done");
    wctl(8'h20);
    wadr(16'h0100);
    wdat(8'h00);
    reqs(0);
    wdat(8'hA5);
    reqs(1);
    check(18'(last_op), 18'(flash_prog_pkg::FOP_ERASE_PAGE));
    radr();
    check(d, 18'h00100);
    $display("test page erase done");
    wctl(8'h10);
    wadr(16'h0200);
    wdat(8'h12);
    wdat(8'h34);
    wctl(8'h01);
    wadr(16'h0200);
    reqs(2);
    rdat();
    rdat();
    check(d, 18'h00048);
    rdat();
    check(d, 18'h000D0);
    reqs(3);
    radr();
    check(d, 18'h00203);
    wctl(8'h02);
    wadr(16'h0200);
    rdat();
    rdat();
    rdat();
    check(d, 18'h00048);
    reqs(1);
    $display("test read modes done");
    wctl(8'h90);
    wadr(16'h007E);
    wdat(8'h77);
    check({last_scr, 1'b0, last_addr}, 18'h2007E);
    wctl(8'h81);
    wadr(16'h007E);
    rdat();
    rdat();
    check(d, 18'h001DC);
    reqs(3);
    $display("test scratchpad done");
    lat = 10'h3FF;
    wctl(8'h10);
    wdat(8'h01);
    rdat();
    check(d, 18'h00005);
    wdat(8'h02);
    reqs(1);
    for (int i = 0; i < 10 && d[0] !== 1'b0; i++) rdat();
    check(18'(d[0]), 18'h00000);
    lat = 10'h002;
    scan(flash_prog_pkg::SEL_DATA, {flash_prog_pkg::OP_WRITE, 8'h33, 10'h000}, sq);
    dup();
    rdat();
    reqs(1);
    $display("test busy done");
    wctl(8'h20);
    foreach (LK[i]) begin
      wadr(LK[i]);
      wdat(8'hA5);
      check(18'(last_op), 18'(flash_prog_pkg::FOP_ERASE_ALL));
    end
    $display("test lock erase done");
    test_done();
  end

  initial begin
    #400000;
    error_cnt++;
    test_done();
  end
endmodule : jtag_flash_program_access_tb
